// ---- rtl/fbl_led_top.sv ----
// The address-and-strobe port and the register addresses were chosen for this implementation.
module fbl_led_top #(
  parameter int unsigned TICK_CYC = fbl_pkg::TICK_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [1:0] i_link_valid,
  input wire logic [1:0] i_link_act,
  input wire logic [3:0] i_al_state,
  input wire logic i_booting,
  input wire logic i_fw_dl,
  input wire logic i_pdi_wd_err,
  input wire logic i_cfg_err,
  input wire logic i_boot_err,
  input wire logic i_auto_chg,
  input wire logic i_sync_err,
  input wire logic i_app_wd_err,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_irq,
  output logic [1:0] o_link_led,
  output logic o_state_led,
  output logic o_err_led,
  output logic [7:0] o_al_change,
  output logic o_safeop_req
);
  localparam int unsigned TW = $clog2(TICK_CYC);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);

  logic [TW-1:0] tick_cnt_r;
  logic tick, flick_r;
  logic [1:0] act_pend_r, act_hold_r;
  logic [2:0] spat, epat, spat_q_r, epat_q_r;
  logic state_gen, err_gen;
  logic test_r, sync_lat_r, sync_q_r, sync_clr;
  logic [2:0] stat_r, mask_r, stat_set, stat_clr;
  logic wr_ctrl, wr_mask, rd_stat;

  // ==========================================================
  // Common time base
  // One shared tick keeps every pattern period an exact multiple
  assign tick = i_ce && (tick_cnt_r == TICK_LAST);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      tick_cnt_r <= '0;
    end else if (i_ce) begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + TW'(1);
    end
  end

  // Flicker phase toggles every tick: 50 ms on, 50 ms off
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      flick_r <= 1'b1;
    end else if (tick) begin
      flick_r <= !flick_r;
    end
  end

  // ==========================================================
  // Link indicators
  // Traffic pulses are short; any pulse in a tick window holds
  // the flicker for the next window so it is visible
  genvar gp;
  generate
    for (gp = 0; gp < fbl_pkg::NUM_PORTS; gp++) begin : g_port
      always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
          act_pend_r[gp] <= 1'b0;
          act_hold_r[gp] <= 1'b0;
          o_link_led[gp] <= 1'b0;
        end else if (i_ce) begin
          act_pend_r[gp] <= i_link_act[gp] || (act_pend_r[gp] && !tick);
          if (tick) begin
            act_hold_r[gp] <= act_pend_r[gp] || i_link_act[gp];
          end
          if (test_r) begin
            o_link_led[gp] <= 1'b1;
          end else if (!i_link_valid[gp]) begin
            o_link_led[gp] <= 1'b0;
          end else if (act_hold_r[gp]) begin
            o_link_led[gp] <= flick_r;
          end else begin
            o_link_led[gp] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Pattern selection
  // Booting, bootstrap and download win over the reported state
  always_comb begin
    if (i_booting || i_fw_dl || i_al_state == fbl_pkg::AL_BOOT) begin
      spat = fbl_pkg::PAT_FLICK;
    end else begin
      case (i_al_state)
        fbl_pkg::AL_OP: spat = fbl_pkg::PAT_ON;
        fbl_pkg::AL_PREOP: spat = fbl_pkg::PAT_BLINK;
        fbl_pkg::AL_SAFEOP: spat = fbl_pkg::PAT_SINGLE;
        fbl_pkg::AL_INIT: spat = fbl_pkg::PAT_OFF;
        default: spat = fbl_pkg::PAT_OFF;
      endcase
    end
  end

  // Error priority: most severe condition owns the red LED
  always_comb begin
    if (i_pdi_wd_err) begin
      epat = fbl_pkg::PAT_ON;
    end else if (i_app_wd_err) begin
      epat = fbl_pkg::PAT_DOUBLE;
    end else if (i_boot_err) begin
      epat = fbl_pkg::PAT_FLICK;
    end else if (i_cfg_err) begin
      epat = fbl_pkg::PAT_BLINK;
    end else if (i_auto_chg || sync_lat_r) begin
      epat = fbl_pkg::PAT_SINGLE;
    end else begin
      epat = fbl_pkg::PAT_OFF;
    end
  end

  fbl_pat_gen u_state_gen (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_tick(tick),
    .i_pat(spat),
    .o_led(state_gen)
  );

  fbl_pat_gen u_err_gen (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_tick(tick),
    .i_pat(epat),
    .o_led(err_gen)
  );

  // Indicator outputs; lamp test lights everything
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_state_led <= 1'b0;
      o_err_led <= 1'b0;
    end else if (i_ce) begin
      o_state_led <= test_r || state_gen;
      o_err_led <= test_r || err_gen;
    end
  end

  // ==========================================================
  // Sync error handling and change flag
  // Latched so a short sync fault still forces the state change;
  // a new fault in the clearing cycle keeps the latch set
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      sync_lat_r <= 1'b0;
      sync_q_r <= 1'b0;
      o_safeop_req <= 1'b0;
      o_al_change <= fbl_pkg::CHG_NONE;
    end else if (i_ce) begin
      sync_lat_r <= i_sync_err || (sync_lat_r && !sync_clr);
      sync_q_r <= i_sync_err;
      o_safeop_req <= i_sync_err || (sync_lat_r && !sync_clr);
      if (i_boot_err || i_auto_chg || sync_lat_r) begin
        o_al_change <= fbl_pkg::CHG_ERR;
      end else begin
        o_al_change <= fbl_pkg::CHG_NONE;
      end
    end
  end

  // ==========================================================
  // Register port
  assign wr_ctrl = i_wr && i_addr == fbl_pkg::REG_CTRL;
  assign wr_mask = i_wr && i_addr == fbl_pkg::REG_MASK;
  assign rd_stat = i_rd && i_addr == fbl_pkg::REG_STAT;
  assign sync_clr = wr_ctrl && i_wdata[fbl_pkg::CTRL_SCLR_BIT];

  // Control and mask
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      test_r <= fbl_pkg::CTRL_TEST_RST;
      mask_r <= fbl_pkg::MASK_RST;
    end else if (i_ce) begin
      if (wr_ctrl) begin
        test_r <= i_wdata[fbl_pkg::CTRL_TEST_BIT];
      end
      if (wr_mask) begin
        mask_r <= i_wdata[fbl_pkg::ST_W-1:0];
      end
    end
  end

  // Sticky events; a set in the read cycle survives the clear
  always_comb begin
    stat_set = '0;
    stat_set[fbl_pkg::ST_SPAT_BIT] = spat != spat_q_r;
    stat_set[fbl_pkg::ST_EPAT_BIT] = epat != epat_q_r;
    stat_set[fbl_pkg::ST_SYNC_BIT] = i_sync_err && !sync_q_r;
    stat_clr = rd_stat ? '1 : '0;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      stat_r <= fbl_pkg::STAT_RST;
      spat_q_r <= fbl_pkg::PAT_OFF;
      epat_q_r <= fbl_pkg::PAT_OFF;
    end else if (i_ce) begin
      stat_r <= (stat_r & ~stat_clr) | stat_set;
      spat_q_r <= spat;
      epat_q_r <= epat;
    end
  end

  assign o_irq = |(stat_r & mask_r);

  // Read data stand for one cycle only; unmapped reads give zero
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_ce) begin
      o_rdata <= 32'h0000_0000;
      if (i_rd) begin
        case (i_addr)
          fbl_pkg::REG_CTRL: o_rdata[fbl_pkg::CTRL_TEST_BIT] <= test_r;
          fbl_pkg::REG_STAT: o_rdata[fbl_pkg::ST_W-1:0] <= stat_r;
          fbl_pkg::REG_MASK: o_rdata[fbl_pkg::ST_W-1:0] <= mask_r;
          fbl_pkg::REG_VIEW: begin
            o_rdata[fbl_pkg::VIEW_SPAT_LSB +: 3] <= spat;
            o_rdata[fbl_pkg::VIEW_EPAT_LSB +: 3] <= epat;
            o_rdata[fbl_pkg::VIEW_LED_LSB +: 4] <=
              {o_err_led, o_state_led, o_link_led};
            o_rdata[fbl_pkg::VIEW_SYNC_BIT] <= sync_lat_r;
          end
          default: o_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  sequence s_op_steady;
    (i_ce && !test_r && i_al_state == fbl_pkg::AL_OP && !i_booting &&
      !i_fw_dl)[*3];
  endsequence
  sequence s_init_steady;
    (i_ce && !test_r && i_al_state == fbl_pkg::AL_INIT && !i_booting &&
      !i_fw_dl)[*3];
  endsequence
  sequence s_pdi_steady;
    (i_ce && !test_r && i_pdi_wd_err)[*3];
  endsequence

  a_link_dark: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    i_ce && !test_r && !i_link_valid[0] |=> !o_link_led[0])
    else $error("link LED lit without link");
  a_link_idle_on: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    i_ce && !test_r && i_link_valid[1] && !act_hold_r[1]
    |=> o_link_led[1])
    else $error("idle link LED not steady");
  a_link_flicker: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    i_ce && !test_r && i_link_valid[0] && act_hold_r[0]
    |=> o_link_led[0] == $past(flick_r))
    else $error("busy link LED not flickering");
  a_op_on: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    s_op_steady |-> o_state_led)
    else $error("state LED dark in operational");
  a_init_dark: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    s_init_steady |-> !o_state_led)
    else $error("state LED lit in init");
  a_boot_flick: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    i_booting |-> spat == fbl_pkg::PAT_FLICK)
    else $error("booting not shown as flicker");
  a_pdi_on: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    s_pdi_steady |-> o_err_led)
    else $error("red LED dark after PDI watchdog");
  a_cfg_blink: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    i_cfg_err && !i_pdi_wd_err && !i_app_wd_err && !i_boot_err
    |-> epat == fbl_pkg::PAT_BLINK)
    else $error("config error not blinking");
  a_chg_flag: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    i_ce && (i_boot_err || i_auto_chg) |=> o_al_change == 8'h01)
    else $error("change flag not set");
  a_sync_safeop: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    i_ce && $rose(i_sync_err) |=> o_safeop_req && sync_lat_r
    ##0 epat == fbl_pkg::PAT_SINGLE || i_pdi_wd_err || i_app_wd_err ||
    i_boot_err || i_cfg_err)
    else $error("sync error not handled");
  a_dbl_select: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    i_app_wd_err && !i_pdi_wd_err |-> epat == fbl_pkg::PAT_DOUBLE)
    else $error("app watchdog not double flash");
  a_tick_wrap: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    tick |=> tick_cnt_r == '0 ##1 !tick)
    else $error("time base did not wrap");
  a_irq_level: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    i_ce && rd_stat && stat_set == '0 |=> !o_irq)
    else $error("interrupt held after status read");
endmodule

// ---- rtl/fbl_pkg.sv ----
package fbl_pkg;
  // ==========================================================
  // Time base
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_MS = 50;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned FLICK_MS = 50;
  localparam int unsigned FLASH_MS = 200;
  localparam int unsigned LONG_MS = 1000;
  // Phase lengths in ticks
  localparam logic [4:0] N_FLICK = 5'(FLICK_MS / TICK_MS);
  localparam logic [4:0] N_FLASH = 5'(FLASH_MS / TICK_MS);
  localparam logic [4:0] N_LONG = 5'(LONG_MS / TICK_MS);

  // ==========================================================
  // Slave state codes
  localparam logic [3:0] AL_INIT = 4'h1;
  localparam logic [3:0] AL_PREOP = 4'h2;
  localparam logic [3:0] AL_BOOT = 4'h3;
  localparam logic [3:0] AL_SAFEOP = 4'h4;
  localparam logic [3:0] AL_OP = 4'h8;
  localparam logic [7:0] CHG_ERR = 8'h01;
  localparam logic [7:0] CHG_NONE = 8'h00;
  localparam int unsigned NUM_PORTS = 2;

  // ==========================================================
  // Patterns and phases
  typedef enum logic [2:0] {
    PAT_OFF = 3'h0,
    PAT_ON = 3'h1,
    PAT_FLICK = 3'h2,
    PAT_BLINK = 3'h3,
    PAT_SINGLE = 3'h4,
    PAT_DOUBLE = 3'h5
  } fbl_pat_e;
  typedef enum logic [1:0] {
    PH_ON1 = 2'h0,
    PH_OFF1 = 2'h1,
    PH_ON2 = 2'h3,
    PH_OFF2 = 2'h2
  } fbl_phase_e;

  // ==========================================================
  // Register map
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_MASK = 4'h8;
  localparam logic [3:0] REG_VIEW = 4'hC;
  localparam int unsigned CTRL_TEST_BIT = 0;
  localparam int unsigned CTRL_SCLR_BIT = 1;
  localparam logic CTRL_TEST_RST = 1'h0;
  localparam int unsigned ST_W = 3;
  localparam int unsigned ST_SPAT_BIT = 0;
  localparam int unsigned ST_EPAT_BIT = 1;
  localparam int unsigned ST_SYNC_BIT = 2;
  localparam logic [2:0] STAT_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam int unsigned VIEW_SPAT_LSB = 0;
  localparam int unsigned VIEW_EPAT_LSB = 4;
  localparam int unsigned VIEW_LED_LSB = 8;
  localparam int unsigned VIEW_SYNC_BIT = 12;
endpackage

// ---- rtl/fbl_pat_gen.sv ----
module fbl_pat_gen (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_tick,
  input wire logic [2:0] i_pat,
  output logic o_led
);
  fbl_pkg::fbl_pat_e pat_r;
  fbl_pkg::fbl_phase_e ph_r, ph_nxt, ph_after;
  logic [4:0] cnt_r, cnt_nxt, dur;
  logic restart, lit_nxt;

  // ==========================================================
  // Phase sequencing
  assign restart = i_pat != pat_r;

  // Length of the running phase, in ticks
  always_comb begin
    case (pat_r)
      fbl_pkg::PAT_FLICK: dur = fbl_pkg::N_FLICK;
      fbl_pkg::PAT_SINGLE: dur = (ph_r == fbl_pkg::PH_ON1) ?
        fbl_pkg::N_FLASH : fbl_pkg::N_LONG;
      fbl_pkg::PAT_DOUBLE: dur = (ph_r == fbl_pkg::PH_OFF2) ?
        fbl_pkg::N_LONG : fbl_pkg::N_FLASH;
      default: dur = fbl_pkg::N_FLASH;
    endcase
  end

  // Successor phase; only the double flash uses the second pair
  always_comb begin
    case (ph_r)
      fbl_pkg::PH_ON1: ph_after = fbl_pkg::PH_OFF1;
      fbl_pkg::PH_OFF1: ph_after = (pat_r == fbl_pkg::PAT_DOUBLE) ?
        fbl_pkg::PH_ON2 : fbl_pkg::PH_ON1;
      fbl_pkg::PH_ON2: ph_after = fbl_pkg::PH_OFF2;
      default: ph_after = fbl_pkg::PH_ON1;
    endcase
  end

  // A new pattern other than off starts lit; phases advance on ticks only
  always_comb begin
    ph_nxt = ph_r;
    cnt_nxt = cnt_r;
    if (restart) begin
      ph_nxt = fbl_pkg::PH_ON1;
      cnt_nxt = 5'h00;
    end else if (i_tick) begin
      if (cnt_r == dur - 5'h01) begin
        ph_nxt = ph_after;
        cnt_nxt = 5'h00;
      end else begin
        cnt_nxt = cnt_r + 5'h01;
      end
    end
    case (fbl_pkg::fbl_pat_e'(i_pat))
      fbl_pkg::PAT_OFF: lit_nxt = 1'b0;
      fbl_pkg::PAT_ON: lit_nxt = 1'b1;
      default: lit_nxt = (ph_nxt == fbl_pkg::PH_ON1) ||
        (ph_nxt == fbl_pkg::PH_ON2);
    endcase
  end

  // Pattern state
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      pat_r <= fbl_pkg::PAT_OFF;
      ph_r <= fbl_pkg::PH_ON1;
      cnt_r <= 5'h00;
      o_led <= 1'b0;
    end else if (i_ce) begin
      pat_r <= fbl_pkg::fbl_pat_e'(i_pat);
      ph_r <= ph_nxt;
      cnt_r <= cnt_nxt;
      o_led <= lit_nxt;
    end
  end

  // ==========================================================
  // Checks
  sequence s_phase_end(fbl_pkg::fbl_pat_e p, fbl_pkg::fbl_phase_e h,
                       logic [4:0] n);
    i_ce && !restart && i_tick && pat_r == p && ph_r == h &&
      cnt_r == n - 5'h01;
  endsequence

  a_restart_lit: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    i_ce && restart && i_pat != 3'h0 |=> o_led && cnt_r == 5'h00)
    else $error("new pattern did not start lit");
  a_blink_off: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    s_phase_end(fbl_pkg::PAT_BLINK, fbl_pkg::PH_ON1, fbl_pkg::N_FLASH)
    |=> !o_led && ph_r == fbl_pkg::PH_OFF1)
    else $error("blink lit phase wrong length");
  a_single_relit: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    s_phase_end(fbl_pkg::PAT_SINGLE, fbl_pkg::PH_OFF1, fbl_pkg::N_LONG)
    |=> o_led && ph_r == fbl_pkg::PH_ON1)
    else $error("single flash dark phase wrong");
  a_double_second: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    s_phase_end(fbl_pkg::PAT_DOUBLE, fbl_pkg::PH_OFF1, fbl_pkg::N_FLASH)
    |=> o_led && ph_r == fbl_pkg::PH_ON2)
    else $error("double flash second flash missing");
  a_phase_hold: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    i_ce && !i_tick && !restart |=> ph_r == $past(ph_r))
    else $error("phase moved between ticks");
endmodule

// ---- test/fbl_slave_model.sv ----
// ==========================================================
// Slave state machine and link monitor stand-in
module fbl_slave_model (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [3:0] i_target,
  input wire logic [1:0] i_links,
  input wire logic [1:0] i_traffic,
  input wire logic i_safeop_req,
  output logic [3:0] o_al_state,
  output logic [1:0] o_link_valid,
  output logic [1:0] o_link_act
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] gap_r;

  // State follows the master; a latched sync error forces SAFE-OP
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_al_state <= fbl_pkg::AL_INIT;
    end else if (i_safeop_req) begin
      o_al_state <= fbl_pkg::AL_SAFEOP;
    end else begin
      o_al_state <= i_target;
    end
  end

  // Frames arrive every fourth cycle, only on a valid link
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      gap_r <= 2'h0;
      o_link_valid <= 2'h0;
      o_link_act <= 2'h0;
    end else begin
      gap_r <= gap_r + 2'h1;
      o_link_valid <= i_links;
      o_link_act <= (gap_r == 2'h0) ? (i_traffic & i_links) : 2'h0;
    end
  end
endmodule

// ---- test/fbl_led_top_tb_top.sv ----
module fbl_led_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Short time base: one tick is 20 cycles
  localparam int TC = 20;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wrs = 1'b0;
  logic rds = 1'b0;
  logic sync = 1'b0;
  logic boot = 1'b0;
  logic fwdl = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [3:0] tgt = fbl_pkg::AL_INIT;
  logic [31:0] wdata = 32'h0000_0000;
  logic [4:0] ev = 5'h00;
  logic [1:0] links = 2'h0;
  logic [1:0] traf = 2'h0;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [1:0] lv;
  logic [1:0] la;
  logic [1:0] lled;
  logic [3:0] al;
  logic [7:0] chg;
  logic irq;
  logic sled;
  logic eled;
  logic sreq;
  wire [3:0] leds = {eled, sled, lled};
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  fbl_led_top #(.TICK_CYC(TC)) dut (
    .i_ref_clk(clk), .i_rstn(rstn), .i_ce(1'b1),
    .i_link_valid(lv), .i_link_act(la), .i_al_state(al),
    .i_booting(boot), .i_fw_dl(fwdl), .i_pdi_wd_err(ev[0]),
    .i_cfg_err(ev[1]), .i_boot_err(ev[2]), .i_auto_chg(ev[3]),
    .i_sync_err(sync), .i_app_wd_err(ev[4]), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wrs), .i_rd(rds), .o_rdata(rdata),
    .o_irq(irq), .o_link_led(lled), .o_state_led(sled),
    .o_err_led(eled), .o_al_change(chg), .o_safeop_req(sreq)
  );

  fbl_slave_model far (
    .i_ref_clk(clk), .i_rstn(rstn), .i_target(tgt), .i_links(links),
    .i_traffic(traf), .i_safeop_req(sreq), .o_al_state(al),
    .o_link_valid(lv), .o_link_act(la)
  );

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A hang counts as a failure
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      results();
    end
  end

  // ==========================================================
  // Register port
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wrs <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wrs <= 1'b0;
  endtask

  // Data stand only in the cycle after the read edge
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    rds <= 1'b1;
    addr <= a;
    @(posedge clk);
    rds <= 1'b0;
    #1 d = rdata;
  endtask

  // ==========================================================
  // LED observers
  task automatic hold(input int s, input logic x);
    int n;
    n = 0;
    // Sample 1 ns after the edge so the LED flops have settled
    repeat (300) begin
      @(posedge clk);
      #1;
      if (leds[s] === x) n++;
    end
    chk(n, 300);
  endtask

  // Skips the partial first phase, then times four whole phases
  task automatic pat(input int s, input int e0, e1, e2, e3);
    int r[4];
    int k;
    k = 0;
    while (leds[s] !== 1'b0 && k < 3000) begin
      @(posedge clk);
      #1;
      k++;
    end
    while (leds[s] !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #1;
      k++;
    end
    for (int j = 0; j < 4; j++) begin
      r[j] = 0;
      while (leds[s] === (j % 2 == 0) && k < 6000) begin
        @(posedge clk);
        #1;
        r[j]++;
        k++;
      end
    end
    chk(r[0], e0);
    chk(r[1], e1);
    chk(r[2], e2);
    chk(r[3], e3);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    wr(4'h2, 32'hFFFF_FFFF);
    // Reset values, unmapped address, ignored write
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4), v);
      chk(v, 32'h0000_0000);
    end
    rd(4'h2, v);
    chk(v, 32'h0000_0000);
    links <= 2'h1;
    // Model flop plus LED flop before the link LED follows
    repeat (4) @(posedge clk);
    hold(0, 1'b1);
    hold(1, 1'b0);
    traf <= 2'h1;
    pat(0, TC, TC, TC, TC);
    // Masked change leaves the interrupt low
    tgt <= fbl_pkg::AL_PREOP;
    repeat (6) @(posedge clk);
    chk(irq, 1'b0);
    rd(fbl_pkg::REG_STAT, v);
    wr(fbl_pkg::REG_MASK, 32'h0000_0001);
    rd(fbl_pkg::REG_MASK, v);
    chk(v, 32'h0000_0001);
    tgt <= fbl_pkg::AL_OP;
    repeat (6) @(posedge clk);
    chk(irq, 1'b1);
    hold(2, 1'b1);
    rd(fbl_pkg::REG_STAT, v);
    chk(v, 32'h0000_0001);
    chk(irq, 1'b0);
    tgt <= fbl_pkg::AL_PREOP;
    pat(2, 4 * TC, 4 * TC, 4 * TC, 4 * TC);
    // Change in a dark phase must light at once
    while (sled !== 1'b0) @(posedge clk);
    tgt <= fbl_pkg::AL_SAFEOP;
    repeat (5) @(posedge clk);
    chk(sled, 1'b1);
    pat(2, 4 * TC, 20 * TC, 4 * TC, 20 * TC);
    // Bootstrap, booting, download
    tgt <= fbl_pkg::AL_BOOT;
    pat(2, TC, TC, TC, TC);
    tgt <= fbl_pkg::AL_INIT;
    boot <= 1'b1;
    pat(2, TC, TC, TC, TC);
    boot <= 1'b0;
    fwdl <= 1'b1;
    pat(2, TC, TC, TC, TC);
    fwdl <= 1'b0;
    repeat (4) @(posedge clk);
    hold(2, 1'b0);
    // Error sources one at a time, then priority
    ev <= 5'h01;
    repeat (4) @(posedge clk);
    hold(3, 1'b1);
    ev <= 5'h02;
    pat(3, 4 * TC, 4 * TC, 4 * TC, 4 * TC);
    chk(chg, fbl_pkg::CHG_NONE);
    ev <= 5'h04;
    pat(3, TC, TC, TC, TC);
    chk(chg, fbl_pkg::CHG_ERR);
    rd(fbl_pkg::REG_VIEW, v);
    chk(v[6:4], 3'h2);
    ev <= 5'h08;
    pat(3, 4 * TC, 20 * TC, 4 * TC, 20 * TC);
    chk(chg, fbl_pkg::CHG_ERR);
    ev <= 5'h10;
    pat(3, 4 * TC, 20 * TC, 4 * TC, 4 * TC);
    ev <= 5'h11;
    repeat (4) @(posedge clk);
    hold(3, 1'b1);
    ev <= 5'h00;
    // Sync error pulse forces SAFE-OP and an autonomous change
    tgt <= fbl_pkg::AL_OP;
    sync <= 1'b1;
    @(posedge clk);
    sync <= 1'b0;
    repeat (4) @(posedge clk);
    chk(sreq, 1'b1);
    chk(chg, fbl_pkg::CHG_ERR);
    pat(3, 4 * TC, 20 * TC, 4 * TC, 20 * TC);
    pat(2, 4 * TC, 20 * TC, 4 * TC, 20 * TC);
    rd(fbl_pkg::REG_STAT, v);
    chk(v & 32'h0000_0004, 32'h0000_0004);
    wr(fbl_pkg::REG_CTRL, 32'h0000_0002);
    repeat (4) @(posedge clk);
    chk(sreq, 1'b0);
    chk(chg, fbl_pkg::CHG_NONE);
    // Lamp test lights everything
    links <= 2'h0;
    tgt <= fbl_pkg::AL_INIT;
    wr(fbl_pkg::REG_CTRL, 32'h0000_0001);
    repeat (4) @(posedge clk);
    chk(leds, 4'hF);
    rd(fbl_pkg::REG_CTRL, v);
    chk(v, 32'h0000_0001);
    results();
  end
endmodule
